// ---- rtl/itc_defs.svh ----
/*
 two-wire slave translator constants.
 assumes: included by the package, the slave and the bench.
*/
// Contract
// - two-wire slave at fast-mode rate; master owns SCL
// - bus transactions become internal serial commands
// - read: write command plus two address bytes, then read
// - each ack of a read fetches byte, then bumps address
// - fetched byte shifts out over next eight SCL clocks
// - stale read setup repeats first-address byte every ack
// - each written byte stored (EEPROM only after enable), then address bumped
// - bank select 0 reaches registers, 1 reaches EEPROM
// - status poll: status command write, then one-byte read
// - status bit 0 is 1 while page transfer busy
// - no high-speed, 10-bit, general call, reset, ID
// - never stretches SCL
// - 7-bit address from three strap values latched once after reset release
// - all bytes shift MSB first
// - repeated START acts as STOP plus START
// - soft reset leaves this port running
// - commands: enable 06, write 02, read 03, status 05
// - EEPROM write address wraps inside 32-byte page
`ifndef ITC_DEFS_SVH
`define ITC_DEFS_SVH
// strap addresses, arbitrary values
`define ITC_SLV_ADDR0 7'h58
`define ITC_SLV_ADDR1 7'h59
`define ITC_SLV_ADDR2 7'h5A
`define ITC_CMD_WREN 8'h06
`define ITC_CMD_WR 8'h02
`define ITC_CMD_RD 8'h03
`define ITC_CMD_STAT 8'h05
`define ITC_BANK_ADDR 16'h0000
`define ITC_PAGE_LSB 5'h1F
`define ITC_STRAP_WAIT 2'h2
`endif

// ---- rtl/itc_pkg.sv ----
/*
 types for the two-wire translator.
 assumes: itc_defs.svh on the include path.
*/
package itc_pkg;
`include "itc_defs.svh"
   typedef logic [7:0] itc_byte_t;
   typedef logic [15:0] itc_addr_t;
   typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_ADDR = 3'b001,
      ST_AACK = 3'b010, ST_WBYTE = 3'b011, ST_WACK = 3'b100,
      ST_RBYTE = 3'b101, ST_RACK = 3'b110} itc_state_t;
   typedef enum logic [2:0] {OP_WREN = 3'b000, OP_ADRHI = 3'b001,
      OP_ADRLO = 3'b010, OP_WR = 3'b011, OP_RD = 3'b100,
      OP_RDRPT = 3'b101, OP_STAT = 3'b110, OP_END = 3'b111} itc_op_t;
   typedef struct packed {
      logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
      logic [1:0] sel_s1, sel_s2, strap_cnt;
      logic [6:0] my_addr;
      itc_state_t state;
      logic [3:0] cnt;
      itc_byte_t sh, tx, cmd, dat;
      logic rw, other, wtx, rtx, fresh, stat, sda_oe_n, sda_o;
      logic [1:0] idx;
      logic req_tgl, ack_s1, ack_s2, ack_d, rd_wait;
      itc_op_t op;
   } itc_core_t;
   typedef struct packed {
      logic req_s1, req_s2, req_d, ack_tgl;
      itc_addr_t addr, mem_addr;
      logic bank, wel, wrote_ee, rd_pend, mem_wr, mem_rd, mem_bank, commit;
      itc_byte_t rdata, mem_wdata;
   } itc_cmd_t;
endpackage : itc_pkg

// ---- rtl/itc_i2c_slave.sv ----
/*
 two-wire slave port that turns bus transfers into
 internal serial commands on the command clock.
 assumes: SDA resolved outside from o_sda_oe_n; memory
 answers i_mem_rdata one command clock after o_mem_rd.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itc_defs.svh"
module itc_i2c_slave (
   // core clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // command side clock
   input wire logic i_cmd_clk,
   // bus pins and address straps
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   input wire logic [1:0] i_addr_sel,
   // memory side, command clock
   output logic o_mem_wr,
   output logic o_mem_rd,
   output logic o_mem_bank,
   output itc_pkg::itc_addr_t o_mem_addr,
   output itc_pkg::itc_byte_t o_mem_wdata,
   input wire itc_pkg::itc_byte_t i_mem_rdata,
   input wire logic i_ee_busy,
   output logic o_ee_commit,
   output logic o_bank_select
);
   import itc_pkg::*;

   // ***********************
   // core domain
   // ***********************
   itc_core_t c_reg, c_next;
   itc_cmd_t m_reg, m_next;
   logic start_det, stop_det, scl_rise, scl_fall;

   // only i_rst_n resets this port, soft reset never reaches it
   assign start_det = c_reg.scl_s2 & c_reg.scl_d & c_reg.sda_d & ~c_reg.sda_s2;
   assign stop_det = c_reg.scl_s2 & c_reg.scl_d & ~c_reg.sda_d & c_reg.sda_s2;
   assign scl_rise = c_reg.scl_s2 & ~c_reg.scl_d;
   assign scl_fall = ~c_reg.scl_s2 & c_reg.scl_d;

   // protocol engine; 200 MHz sampling covers 400 kbit/s
   always_comb begin
      c_next = c_reg;
      c_next.scl_s1 = i_scl;
      c_next.scl_s2 = c_reg.scl_s1;
      c_next.scl_d = c_reg.scl_s2;
      c_next.sda_s1 = i_sda;
      c_next.sda_s2 = c_reg.sda_s1;
      c_next.sda_d = c_reg.sda_s2;
      c_next.sel_s1 = i_addr_sel;
      c_next.sel_s2 = c_reg.sel_s1;
      c_next.ack_s1 = m_reg.ack_tgl;
      c_next.ack_s2 = c_reg.ack_s1;
      c_next.ack_d = c_reg.ack_s2;
      // straps caught once after reset release
      if (c_reg.strap_cnt != 2'h3) begin
         c_next.strap_cnt = c_reg.strap_cnt + 2'h1;
         if (c_reg.strap_cnt == `ITC_STRAP_WAIT) begin
            case (c_reg.sel_s2)
               2'h0: c_next.my_addr = `ITC_SLV_ADDR0;
               2'h1: c_next.my_addr = `ITC_SLV_ADDR1;
               default: c_next.my_addr = `ITC_SLV_ADDR2;
            endcase
         end
      end
      // read answer lands in the transmit shifter
      if ((c_reg.ack_s2 != c_reg.ack_d) && c_reg.rd_wait) begin
         c_next.tx = m_reg.rdata;
         c_next.rd_wait = 1'b0;
      end
      if (start_det || stop_det) begin
         // both conditions end the transfer the same way
         if (c_reg.wtx) begin
            c_next.req_tgl = ~c_reg.req_tgl;
            c_next.op = OP_END;
            c_next.fresh = (c_reg.cmd == `ITC_CMD_RD) && (c_reg.idx == 2'h3);
            c_next.stat = (c_reg.cmd == `ITC_CMD_STAT);
         end else if (c_reg.rtx || c_reg.other) begin
            // any other transfer makes a read setup stale
            c_next.fresh = 1'b0;
            c_next.stat = 1'b0;
         end
         c_next.state = start_det ? ST_ADDR : ST_IDLE;
         c_next.cnt = 4'h0;
         c_next.idx = 2'h0;
         c_next.wtx = 1'b0;
         c_next.rtx = 1'b0;
         c_next.other = 1'b0;
         c_next.sda_oe_n = 1'b1;
      end else begin
         case (c_reg.state)
            ST_ADDR: begin
               if (scl_rise && c_reg.cnt != 4'h8) begin
                  c_next.sh = {c_reg.sh[6:0], c_reg.sda_s2};
                  c_next.cnt = c_reg.cnt + 4'h1;
               end
               if (scl_fall && c_reg.cnt == 4'h8) begin
                  // 7-bit match only; no general call or 10-bit
                  if (c_reg.sh[7:1] == c_reg.my_addr) begin
                     c_next.state = ST_AACK;
                     c_next.sda_oe_n = 1'b0;
                     c_next.rw = c_reg.sh[0];
                     if (c_reg.sh[0]) begin
                        c_next.rtx = 1'b1;
                        c_next.rd_wait = 1'b1;
                        c_next.req_tgl = ~c_reg.req_tgl;
                        // status poll or read command
                        c_next.op = c_reg.stat ? OP_STAT :
                                    c_reg.fresh ? OP_RD : OP_RDRPT;
                     end else begin
                        c_next.wtx = 1'b1;
                     end
                  end else begin
                     c_next.other = 1'b1;
                     c_next.state = ST_IDLE;
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  c_next.cnt = 4'h0;
                  c_next.state = c_reg.rw ? ST_RBYTE : ST_WBYTE;
                  c_next.sda_oe_n = c_reg.rw ? c_next.tx[7] : 1'b1;
               end
            end
            ST_WBYTE: begin
               if (scl_rise && c_reg.cnt != 4'h8) begin
                  c_next.sh = {c_reg.sh[6:0], c_reg.sda_s2};
                  c_next.cnt = c_reg.cnt + 4'h1;
               end
               if (scl_fall && c_reg.cnt == 4'h8) begin
                  c_next.sda_oe_n = 1'b0;
                  c_next.state = ST_WACK;
                  c_next.dat = c_reg.sh;
                  if (c_reg.idx != 2'h3) begin
                     c_next.idx = c_reg.idx + 2'h1;
                  end
                  // byte order: command, high, low, data
                  case (c_reg.idx)
                     2'h0: begin
                        c_next.cmd = c_reg.sh;
                        if (c_reg.sh == `ITC_CMD_WREN) begin
                           c_next.req_tgl = ~c_reg.req_tgl;
                           c_next.op = OP_WREN;
                        end
                     end
                     2'h1: begin
                        c_next.req_tgl = ~c_reg.req_tgl;
                        c_next.op = OP_ADRHI;
                     end
                     2'h2: begin
                        c_next.req_tgl = ~c_reg.req_tgl;
                        c_next.op = OP_ADRLO;
                     end
                     default: begin
                        if (c_reg.cmd == `ITC_CMD_WR) begin
                           c_next.req_tgl = ~c_reg.req_tgl;
                           c_next.op = OP_WR;
                        end
                     end
                  endcase
               end
            end
            ST_WACK: begin
               if (scl_fall) begin
                  c_next.sda_oe_n = 1'b1;
                  c_next.cnt = 4'h0;
                  c_next.state = ST_WBYTE;
               end
            end
            ST_RBYTE: begin
               // next bit on each fall, eight in all
               if (scl_fall) begin
                  c_next.cnt = c_reg.cnt + 4'h1;
                  if (c_reg.cnt == 4'h7) begin
                     c_next.sda_oe_n = 1'b1;
                     c_next.state = ST_RACK;
                  end else begin
                     c_next.tx = {c_reg.tx[6:0], 1'b0};
                     c_next.sda_oe_n = c_reg.tx[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  if (!c_reg.sda_s2) begin
                     c_next.rd_wait = 1'b1;
                     c_next.req_tgl = ~c_reg.req_tgl;
                     c_next.op = c_reg.stat ? OP_STAT :
                                 c_reg.fresh ? OP_RD : OP_RDRPT;
                  end else begin
                     c_next.state = ST_IDLE;
                  end
               end else if (scl_fall) begin
                  c_next.cnt = 4'h0;
                  c_next.state = ST_RBYTE;
                  c_next.sda_oe_n = c_next.tx[7];
               end
            end
            default: c_next.state = ST_IDLE;
         endcase
      end
   end

   // SDA is only ever pulled low, SCL never driven
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         c_reg <= '0;
         c_reg.scl_s1 <= 1'b1;
         c_reg.scl_s2 <= 1'b1;
         c_reg.scl_d <= 1'b1;
         c_reg.sda_s1 <= 1'b1;
         c_reg.sda_s2 <= 1'b1;
         c_reg.sda_d <= 1'b1;
         c_reg.sda_oe_n <= 1'b1;
      end else begin
         c_reg <= c_next;
      end
   end

   // ***********************
   // command domain
   // ***********************
   // one request at a time; bus bit spacing dwarfs the handshake
   always_comb begin
      m_next = m_reg;
      m_next.mem_wr = 1'b0;
      m_next.mem_rd = 1'b0;
      m_next.commit = 1'b0;
      m_next.req_s1 = c_reg.req_tgl;
      m_next.req_s2 = m_reg.req_s1;
      if (m_reg.rd_pend) begin
         m_next.rdata = i_mem_rdata;
         m_next.rd_pend = 1'b0;
         m_next.ack_tgl = ~m_reg.ack_tgl;
      end else if (m_reg.req_s2 != m_reg.req_d) begin
         m_next.req_d = m_reg.req_s2;
         m_next.ack_tgl = ~m_reg.ack_tgl;
         case (c_reg.op)
            OP_WREN: m_next.wel = 1'b1;
            OP_ADRHI: m_next.addr[15:8] = c_reg.dat;
            OP_ADRLO: m_next.addr[7:0] = c_reg.dat;
            OP_WR: begin
               if (m_reg.addr == `ITC_BANK_ADDR) begin
                  m_next.bank = c_reg.dat[0];
               end else if (!m_reg.bank || m_reg.wel) begin
                  m_next.mem_wr = 1'b1;
                  m_next.mem_addr = m_reg.addr;
                  m_next.mem_wdata = c_reg.dat;
                  m_next.mem_bank = m_reg.bank;
                  m_next.wrote_ee = m_reg.wrote_ee | m_reg.bank;
               end
               // EEPROM writes stay inside their page
               if (m_reg.bank && m_reg.addr[4:0] == `ITC_PAGE_LSB) begin
                  m_next.addr = {m_reg.addr[15:5], 5'h00};
               end else begin
                  m_next.addr = m_reg.addr + 16'h0001;
               end
            end
            OP_RD, OP_RDRPT: begin
               if (m_reg.addr == `ITC_BANK_ADDR) begin
                  m_next.rdata = {7'h00, m_reg.bank};
               end else begin
                  m_next.ack_tgl = m_reg.ack_tgl;
                  m_next.rd_pend = 1'b1;
                  m_next.mem_rd = 1'b1;
                  m_next.mem_addr = m_reg.addr;
                  m_next.mem_bank = m_reg.bank;
               end
               // stale setup rereads the same address
               if (c_reg.op == OP_RD) begin
                  m_next.addr = m_reg.addr + 16'h0001;
               end
            end
            OP_STAT: m_next.rdata = {7'h00, i_ee_busy};
            OP_END: begin
               if (m_reg.wrote_ee) begin
                  m_next.commit = 1'b1;
                  m_next.wel = 1'b0;
                  m_next.wrote_ee = 1'b0;
               end
            end
            default: m_next.ack_tgl = ~m_reg.ack_tgl;
         endcase
      end
   end

   // command clock runs free; reset shared with core
   always_ff @(posedge i_cmd_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         m_reg <= '0;
      end else begin
         m_reg <= m_next;
      end
   end

   // outputs straight from flops
   assign o_sda_out = c_reg.sda_o;
   assign o_sda_oe_n = c_reg.sda_oe_n;
   assign o_mem_wr = m_reg.mem_wr;
   assign o_mem_rd = m_reg.mem_rd;
   assign o_mem_bank = m_reg.mem_bank;
   assign o_mem_addr = m_reg.mem_addr;
   assign o_mem_wdata = m_reg.mem_wdata;
   assign o_ee_commit = m_reg.commit;
   assign o_bank_select = m_reg.bank;

   // ***********************
   // checks
   // ***********************
   a_stop_clears: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      stop_det |=> c_reg.state == ST_IDLE && c_reg.sda_oe_n)
      else $error("stop did not clear the port");
   a_start_addr: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      start_det |=> c_reg.state == ST_ADDR && c_reg.cnt == 4'h0)
      else $error("start did not open address phase");
   a_addr_ack: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      c_reg.state == ST_ADDR && scl_fall && c_reg.cnt == 4'h8 && !start_det
      && !stop_det && c_reg.sh[7:1] == c_reg.my_addr |=> !c_reg.sda_oe_n)
      else $error("own address not acknowledged");
   a_foreign_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      c_reg.other |-> c_reg.sda_oe_n)
      else $error("drove SDA for another address");
   a_msb_out: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      c_reg.state == ST_RBYTE |-> c_reg.sda_oe_n == c_reg.tx[7])
      else $error("read bit not MSB of shifter");
   a_ack_fetch: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      c_reg.state == ST_RACK && scl_rise && !c_reg.sda_s2 && !start_det
      && !stop_det |=> c_reg.req_tgl != $past(c_reg.req_tgl) && c_reg.rd_wait)
      else $error("master ack did not fetch");
   a_eight_bits: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      c_reg.state == ST_RBYTE |-> c_reg.cnt <= 4'h7)
      else $error("read byte exceeded eight bits");
   a_page_wrap: assert property (@(posedge i_cmd_clk) disable iff (!i_rst_n)
      m_reg.req_s2 != m_reg.req_d && !m_reg.rd_pend && c_reg.op == OP_WR
      && m_reg.bank && m_reg.addr[4:0] == 5'h1F |=> m_reg.addr[4:0] == 5'h00
      && m_reg.addr[15:5] == $past(m_reg.addr[15:5]))
      else $error("page address carried");
   a_ee_guard: assert property (@(posedge i_cmd_clk) disable iff (!i_rst_n)
      m_reg.mem_wr && m_reg.mem_bank |-> $past(m_reg.wel))
      else $error("EEPROM written without enable");
   c_read: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      c_reg.state == ST_RACK && scl_rise && !c_reg.sda_s2);
   c_write: cover property (@(posedge i_cmd_clk) disable iff (!i_rst_n) m_reg.mem_wr);
   c_commit: cover property (@(posedge i_cmd_clk) disable iff (!i_rst_n) m_reg.commit);
endmodule : itc_i2c_slave
`default_nettype wire

// ---- sim/itc_i2c_master_model.sv ----
/*
 behavioural two-wire bus master that drives the translator's bus pins.
 assumes: SDA is resolved in the bench with a pull-up, and the master's
 steps are paced by the core clock so that every change lands off its edge.
*/
`timescale 1ns/1ps
`default_nettype none
module itc_i2c_master_model #(
   parameter int Q_CYC = 40
) (
   // pacing clock
   input wire logic i_core_clk,
   // bus pins, SDA pulled low only when o_sda_drv is 0
   output logic o_scl,
   output logic o_sda_drv,
   input wire logic i_sda
);
   // ****************************
   // bus idle level
   // ****************************
   initial begin
      o_scl = 1'b1;
      o_sda_drv = 1'b1;
   end

   // ****************************
   // bit and frame steps
   // ****************************
   // a quarter bit time; the slave's sync delay is far shorter than this
   task automatic quarter();
      repeat (Q_CYC) @(posedge i_core_clk);
      #1;
   endtask : quarter

   // works from idle and from mid-frame, so it also makes a repeated start
   task automatic start();
      o_sda_drv = 1'b1;
      quarter();
      o_scl = 1'b1;
      quarter();
      o_sda_drv = 1'b0;
      quarter();
      o_scl = 1'b0;
      quarter();
   endtask : start

   // every read ends here; a write can end in a repeated start instead
   task automatic stop();
      o_sda_drv = 1'b0;
      quarter();
      o_scl = 1'b1;
      quarter();
      o_sda_drv = 1'b1;
      quarter();
   endtask : stop

   task automatic put_bit(input logic b);
      o_sda_drv = b;
      quarter();
      o_scl = 1'b1;
      quarter();
      quarter();
      o_scl = 1'b0;
      quarter();
   endtask : put_bit

   // sample in the middle of the high phase
   task automatic get_bit(output logic b);
      o_sda_drv = 1'b1;
      quarter();
      o_scl = 1'b1;
      quarter();
      b = i_sda;
      quarter();
      o_scl = 1'b0;
      quarter();
   endtask : get_bit

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      get_bit(b);
      ack = ~b;
   endtask : wr_byte

   // ack high asks for more, low ends the read
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         get_bit(b);
         d[i] = b;
      end
      put_bit(~ack);
   endtask : rd_byte
endmodule : itc_i2c_master_model
`default_nettype wire

// ---- sim/itc_tb.sv ----
/*
 self-checking bench for the two-wire to command translator.
 assumes: itc_pkg compiled first and itc_defs.svh on the include path;
 the memory side is modelled here on the command clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itc_defs.svh"
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb;
   import itc_pkg::*;
   localparam itc_byte_t A_W = {`ITC_SLV_ADDR0, 1'b0};
   localparam itc_byte_t A_R = {`ITC_SLV_ADDR0, 1'b1};
   logic core_clk = 1'b0;
   logic cmd_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ee_busy = 1'b0;
   logic [1:0] addr_sel = 2'h0;
   logic scl, m_sda, sda_out, sda_oe_n, mem_wr, mem_rd, mem_bank, ee_commit, bank_sel;
   wire logic sda;
   itc_addr_t mem_addr;
   itc_byte_t mem_wdata;
   itc_byte_t mem_rdata = 8'h00;
   int fails = 0;
   int checks = 0;
   int commits = 0;
   logic [24:0] wlog[$];
   itc_byte_t mem[logic [16:0]];

   // ****************************
   // clocks, wire and instances
   // ****************************
   always #2.5 core_clk = ~core_clk;
   always #24 cmd_clk = ~cmd_clk;
   // open drain with pull-up: anyone driving low wins
   assign sda = m_sda & (sda_oe_n | sda_out);

   itc_i2c_slave dut_u (
      .i_core_clk(core_clk), .i_rst_n(rst_n), .i_cmd_clk(cmd_clk),
      .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
      .i_addr_sel(addr_sel), .o_mem_wr(mem_wr), .o_mem_rd(mem_rd),
      .o_mem_bank(mem_bank), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
      .i_mem_rdata(mem_rdata), .i_ee_busy(ee_busy), .o_ee_commit(ee_commit),
      .o_bank_select(bank_sel)
   );
   itc_i2c_master_model m_u (
      .i_core_clk(core_clk), .o_scl(scl), .o_sda_drv(m_sda), .i_sda(sda)
   );

   // memory model: logs writes on the edge after the strobe
   always @(posedge cmd_clk) begin
      if (mem_wr) begin
         mem[{mem_bank, mem_addr}] = mem_wdata;
         wlog.push_back({mem_bank, mem_addr, mem_wdata});
      end
      if (ee_commit) begin
         commits++;
      end
   end

   // read data must stand before the edge after o_mem_rd, so answer mid-cycle
   always @(negedge cmd_clk) begin
      if (mem_rd) begin
         mem_rdata <= mem.exists({mem_bank, mem_addr}) ? mem[{mem_bank, mem_addr}] : 8'h00;
      end
   end

   // ****************************
   // shared steps
   // ****************************
   task automatic send(input itc_byte_t b);
      logic ack;
      m_u.wr_byte(b, ack);
      `CHECK(ack, 1'b1)
   endtask : send

   task automatic fetch(input logic ack, input itc_byte_t exp);
      itc_byte_t d;
      m_u.rd_byte(ack, d);
      `CHECK(d, exp)
   endtask : fetch

   task automatic logged(input logic [24:0] exp);
      logic [24:0] w;
      w = wlog.pop_front();
      `CHECK(w, exp)
   endtask : logged

   task automatic set_read(input logic rep);
      m_u.start();
      send(A_W);
      send(`ITC_CMD_RD);
      send(8'h00);
      send(8'h10);
      if (rep) begin
         m_u.stop();
      end
   endtask : set_read

   // ****************************
   // scenarios
   // ****************************
   task automatic t_reg_write();
      m_u.start();
      send(A_W);
      send(`ITC_CMD_WR);
      send(8'h00);
      send(8'h10);
      send(8'hD0);
      send(8'hD1);
      m_u.stop();
      logged({1'b0, 16'h0010, 8'hD0});
      logged({1'b0, 16'h0011, 8'hD1});
   endtask : t_reg_write

   // repeated start straight after the address write keeps the increment
   task automatic t_read_inc();
      set_read(1'b0);
      m_u.start();
      send(A_R);
      fetch(1'b1, 8'hD0);
      fetch(1'b0, 8'hD1);
      m_u.stop();
   endtask : t_read_inc

   // a foreign transfer in between leaves only the first byte to repeat
   task automatic t_stale_read();
      logic ack;
      set_read(1'b1);
      m_u.start();
      m_u.wr_byte({7'h30, 1'b0}, ack);
      `CHECK(ack, 1'b0)
      m_u.stop();
      m_u.start();
      send(A_R);
      fetch(1'b1, 8'hD0);
      fetch(1'b0, 8'hD0);
      m_u.stop();
   endtask : t_stale_read

   task automatic t_eeprom();
      m_u.start();
      send(A_W);
      send(`ITC_CMD_WR);
      send(8'h00);
      send(8'h00);
      send(8'h01);
      m_u.stop();
      `CHECK(bank_sel, 1'b1)
      m_u.start();
      send(A_W);
      send(`ITC_CMD_WREN);
      m_u.stop();
      // two writes per pass; the second pass has no enable and must drop
      for (int k = 0; k < 2; k++) begin
         m_u.start();
         send(A_W);
         send(`ITC_CMD_WR);
         send(8'h00);
         send(8'h3F);
         send(8'hAA);
         send(8'hBB);
         m_u.stop();
         for (int i = 0; i < 60 && commits == k; i++) begin
            @(posedge cmd_clk);
         end
         if (k == 0) begin
            `CHECK(commits, 1)
            logged({1'b1, 16'h003F, 8'hAA});
            logged({1'b1, 16'h0020, 8'hBB});
         end
      end
      `CHECK(commits, 1)
      `CHECK(wlog.size(), 0)
   endtask : t_eeprom

   task automatic t_status();
      for (int k = 1; k >= 0; k--) begin
         @(posedge core_clk);
         #1;
         ee_busy = k[0];
         m_u.start();
         send(A_W);
         send(`ITC_CMD_STAT);
         m_u.start();
         send(A_R);
         fetch(1'b0, {7'h00, k[0]});
         m_u.stop();
      end
   endtask : t_status

   // second reset mid-run with the strap moved: only the new address answers
   task automatic t_strap();
      logic ack;
      @(posedge core_clk);
      #1;
      rst_n = 1'b0;
      addr_sel = 2'h1;
      repeat (3) @(posedge cmd_clk);
      `CHECK(sda_oe_n, 1'b1)
      `CHECK(sda_out, 1'b0)
      `CHECK(bank_sel, 1'b0)
      @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      repeat (10) @(posedge core_clk);
      m_u.start();
      m_u.wr_byte(A_W, ack);
      `CHECK(ack, 1'b0)
      m_u.stop();
      m_u.start();
      send({`ITC_SLV_ADDR1, 1'b0});
      m_u.stop();
   endtask : t_strap

   // ****************************
   // verdict and sequence
   // ****************************
   task automatic finish_test();
      if (fails == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test

   // generous span: the whole sequence needs about 77k core cycles
   initial begin
      repeat (95000) @(posedge core_clk);
      fails++;
      finish_test();
   end

   initial begin
      repeat (3) @(posedge cmd_clk);
      @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      // port is usable once straps are caught; the host boot wait governs
      // configuration of the channel, not this port
      repeat (10) @(posedge core_clk);
      t_reg_write();
      t_read_inc();
      t_stale_read();
      t_eeprom();
      t_status();
      t_strap();
      finish_test();
   end
endmodule : tb
`default_nettype wire
